// file: design/deac_top.sv
// register controller for single byte access to the non-volatile store
`timescale 1ns/100ps
// Summary of operation
// - store holds 128 bytes, addresses 00 to 7f
// - one byte per access via address, value
// - control at 40 in sector 1 only
// - address seven bits, bit 7 reads zero
// - value register eight bits, resets zero
// - control upper nibble zero, lower bits reset
// - store enable must precede any store
// - store start writes value to addressed byte
// - store start clears itself at completion
// - store start ignored without prior enable
// - fetch enable must precede any fetch
// - fetch start loads value and clears itself in the same cycle
// - store completion raises flag software clears
// - store timed by asynchronous internal timer
module deac_top #(
	parameter int STORE_TICKS  = deac_pkg::DEF_STORE_TICKS,
	parameter int FETCH_CYCLES = deac_pkg::DEF_FETCH_CYCLES
) (
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic [7:0] pointerHighByte,
	input  wire logic [7:0] sfrAddr,
	input  wire logic       sfrWrite,
	input  wire logic       sfrRead,
	input  wire logic [7:0] sfrWdata,
	output logic      [7:0] sfrRdata,
	input  wire logic       storeTimerTick,
	input  wire logic       storeDoneClear,
	output logic            storeDoneFlag,
	output logic            storeBusy,
	output logic            fetchBusy
);
	localparam int FETCH_SPAN = FETCH_CYCLES;

	typedef struct packed {
		logic [6:0]           address;
		logic [7:0]           value;
		logic                 storeEnable;
		logic                 storeGo;
		logic                 fetchEnable;
		logic                 fetchGo;
		deac_pkg::deac_state_t state;
		logic [15:0]          count;
		logic                 doneFlag;
		logic [1:0]           tickSync;
		logic                 tickPrev;
		logic                 memWrite;
		logic [7:0]           readData;
	} deac_regs_t;

	deac_regs_t st_q;
	deac_regs_t st_d;
	logic [7:0] memData;
	logic       selCtrl;
	logic       selAddr;
	logic       selValue;
	logic       tickEdge;
	logic [7:0] ctrlView;

	// control only in sector 1, address and value only in sector 0
	assign selCtrl  = (pointerHighByte == deac_pkg::SECTOR_CTRL)
		&& (sfrAddr == deac_pkg::OFF_CONTROL);
	assign selAddr  = (pointerHighByte == deac_pkg::SECTOR_DIRECT)
		&& (sfrAddr == deac_pkg::OFF_ADDRESS);
	assign selValue = (pointerHighByte == deac_pkg::SECTOR_DIRECT)
		&& (sfrAddr == deac_pkg::OFF_VALUE);
	assign tickEdge = st_q.tickSync[1] & ~st_q.tickPrev;

	always_comb begin
		ctrlView = 8'h00;
		ctrlView[deac_pkg::BIT_STORE_EN] = st_q.storeEnable;
		ctrlView[deac_pkg::BIT_STORE_GO] = st_q.storeGo;
		ctrlView[deac_pkg::BIT_FETCH_EN] = st_q.fetchEnable;
		ctrlView[deac_pkg::BIT_FETCH_GO] = st_q.fetchGo;
	end

	always_comb begin
		st_d          = st_q;
		st_d.memWrite = 1'b0;
		st_d.tickSync = {st_q.tickSync[0], storeTimerTick};
		st_d.tickPrev = st_q.tickSync[1];
		// register reads answer one cycle later
		if (sfrRead) begin
			if (selCtrl) begin
				st_d.readData = ctrlView;
			end else if (selAddr) begin
				st_d.readData = {1'b0, st_q.address};
			end else if (selValue) begin
				st_d.readData = st_q.value;
			end else begin
				st_d.readData = 8'h00;
			end
		end
		if (sfrWrite && selAddr) begin
			st_d.address = sfrWdata[6:0];
		end
		if (sfrWrite && selValue) begin
			st_d.value = sfrWdata;
		end
		if (sfrWrite && selCtrl) begin
			st_d.storeEnable = sfrWdata[deac_pkg::BIT_STORE_EN];
			st_d.fetchEnable = sfrWdata[deac_pkg::BIT_FETCH_EN];
			if (st_q.state == deac_pkg::ST_IDLE) begin
				// store wins if both starts arrive together
				if (sfrWdata[deac_pkg::BIT_STORE_GO] && st_q.storeEnable) begin
					st_d.storeGo = 1'b1;
					st_d.state   = deac_pkg::ST_STORE;
					st_d.count   = 16'h0000;
				end else if (sfrWdata[deac_pkg::BIT_FETCH_GO] && st_q.fetchEnable) begin
					st_d.fetchGo = 1'b1;
					st_d.state   = deac_pkg::ST_FETCH;
					st_d.count   = 16'h0000;
				end
			end
		end
		unique case (st_q.state)
			deac_pkg::ST_IDLE: begin
			end
			deac_pkg::ST_STORE: begin
				if (tickEdge) begin
					if (st_q.count == 16'(STORE_TICKS - 1)) begin
						st_d.memWrite = 1'b1;
						st_d.storeGo  = 1'b0;
						st_d.doneFlag = 1'b1;
						st_d.state    = deac_pkg::ST_IDLE;
					end else begin
						st_d.count = st_q.count + 16'h0001;
					end
				end
			end
			deac_pkg::ST_FETCH: begin
				if (st_q.count == 16'(FETCH_CYCLES - 1)) begin
					st_d.value   = memData;
					st_d.fetchGo = 1'b0;
					st_d.state   = deac_pkg::ST_IDLE;
				end else begin
					st_d.count = st_q.count + 16'h0001;
				end
			end
			default: begin
				st_d.state = deac_pkg::ST_IDLE;
			end
		endcase
		// a completion in the clearing cycle keeps the flag set, even if already set
		if (storeDoneClear && !st_d.memWrite) begin
			st_d.doneFlag = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q.address     <= deac_pkg::RST_ADDRESS[6:0];
			st_q.value       <= deac_pkg::RST_VALUE;
			st_q.storeEnable <= deac_pkg::RST_CONTROL[deac_pkg::BIT_STORE_EN];
			st_q.storeGo     <= deac_pkg::RST_CONTROL[deac_pkg::BIT_STORE_GO];
			st_q.fetchEnable <= deac_pkg::RST_CONTROL[deac_pkg::BIT_FETCH_EN];
			st_q.fetchGo     <= deac_pkg::RST_CONTROL[deac_pkg::BIT_FETCH_GO];
			st_q.state       <= deac_pkg::ST_IDLE;
			st_q.count       <= 16'h0000;
			st_q.doneFlag    <= 1'b0;
			st_q.tickSync    <= 2'h0;
			st_q.tickPrev    <= 1'b0;
			st_q.memWrite    <= 1'b0;
			st_q.readData    <= 8'h00;
		end else begin
			st_q <= st_d;
		end
	end

	deac_store_mem #(
		.DEPTH (deac_pkg::MEM_DEPTH),
		.AW    (deac_pkg::ADDR_W),
		.DW    (deac_pkg::DATA_W)
	) u_mem (
		.mclk      (mclk),
		.writeEn   (st_q.memWrite),
		.writeAddr (st_q.address),
		.writeData (st_q.value),
		.readAddr  (st_q.address),
		.readData  (memData)
	);

	assign sfrRdata      = st_q.readData;
	assign storeDoneFlag = st_q.doneFlag;
	assign storeBusy     = st_q.storeGo;
	assign fetchBusy     = st_q.fetchGo;

	chk_store_gate: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(st_q.storeGo) |-> $past(st_q.storeEnable))
		else $error("store started without enable");

	chk_fetch_gate: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(st_q.fetchGo) |-> $past(st_q.fetchEnable))
		else $error("fetch started without enable");

	chk_fetch_span: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(st_q.fetchGo) |-> st_q.fetchGo [*1] ##[1:FETCH_SPAN] !st_q.fetchGo)
		else $error("fetch start bit not cleared in time");

	chk_addr_top_zero: assert property (@(posedge mclk) disable iff (!reset_n)
		(sfrRead && selAddr) |=> sfrRdata[7] == 1'b0)
		else $error("address bit 7 read as one");

	chk_ctrl_upper: assert property (@(posedge mclk) disable iff (!reset_n)
		(sfrRead && selCtrl) |=> sfrRdata[7:4] == 4'h0)
		else $error("control upper bits not zero");

	chk_done_on_end: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(st_q.storeGo) |-> st_q.doneFlag && st_q.memWrite)
		else $error("store end without flag or write");

	chk_done_set_wins: assert property (@(posedge mclk) disable iff (!reset_n)
		st_q.memWrite |-> st_q.doneFlag)
		else $error("store end flag lost to clear");

	chk_sector_guard: assert property (@(posedge mclk) disable iff (!reset_n)
		(sfrWrite && sfrAddr == deac_pkg::OFF_CONTROL
			&& pointerHighByte != deac_pkg::SECTOR_CTRL && st_q.state == deac_pkg::ST_IDLE)
		|=> $stable(st_q.storeEnable) && $stable(st_q.fetchEnable))
		else $error("control changed outside sector 1");

	chk_write_in_store: assert property (@(posedge mclk) disable iff (!reset_n)
		st_q.memWrite |-> $past(st_q.state) == deac_pkg::ST_STORE && !st_q.storeGo)
		else $error("store write outside store cycle");

	chk_store_waits: assert property (@(posedge mclk) disable iff (!reset_n)
		(st_q.storeGo && !tickEdge) |=> st_q.storeGo)
		else $error("store ended without timer tick");
endmodule

// file: include/deac_pkg.sv
// constants and types shared by the byte store access controller
package deac_pkg;
	localparam int          MEM_DEPTH      = 128;
	localparam int          ADDR_W         = 7;
	localparam int          DATA_W         = 8;
	localparam int          CNT_W          = 16;
	// register locations as seen through the special function register port
	localparam logic [7:0]  SECTOR_DIRECT  = 8'h00;
	localparam logic [7:0]  SECTOR_CTRL    = 8'h01;
	localparam logic [7:0]  OFF_CONTROL    = 8'h40;
	localparam logic [7:0]  OFF_ADDRESS    = 8'h2e;
	localparam logic [7:0]  OFF_VALUE      = 8'h2f;
	// control field positions
	localparam int          BIT_STORE_EN   = 3;
	localparam int          BIT_STORE_GO   = 2;
	localparam int          BIT_FETCH_EN   = 1;
	localparam int          BIT_FETCH_GO   = 0;
	localparam logic [7:0]  RST_CONTROL    = 8'h00;
	localparam logic [7:0]  RST_ADDRESS    = 8'h00;
	localparam logic [7:0]  RST_VALUE      = 8'h00;
	// default timing counts
	localparam int          DEF_STORE_TICKS  = 4;
	localparam int          DEF_FETCH_CYCLES = 2;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_STORE = 3'b010,
		ST_FETCH = 3'b100
	} deac_state_t;
endpackage

// file: design/deac_store_mem.sv
// byte store array with registered read data
`timescale 1ns/100ps
module deac_store_mem #(
	parameter int DEPTH  = deac_pkg::MEM_DEPTH,
	parameter int AW     = deac_pkg::ADDR_W,
	parameter int DW     = deac_pkg::DATA_W
) (
	input  wire logic          mclk,
	input  wire logic          writeEn,
	input  wire logic [AW-1:0] writeAddr,
	input  wire logic [DW-1:0] writeData,
	input  wire logic [AW-1:0] readAddr,
	output logic      [DW-1:0] readData
);
	logic [DW-1:0] cells [DEPTH];

	always_ff @(posedge mclk) begin
		if (writeEn) begin
			cells[writeAddr] <= writeData;
		end
		readData <= cells[readAddr];
	end
endmodule

// file: sim/deac_top_tb.sv
// self-checking bench for the byte store access controller
`timescale 1ns/100ps
module deac_top_tb;
	localparam int STK = 2;
	localparam int FCY = 2;
	logic       mclk;
	logic       reset_n;
	logic [7:0] pointerHighByte;
	logic [7:0] sfrAddr;
	logic       sfrWrite;
	logic       sfrRead;
	logic [7:0] sfrWdata;
	logic [7:0] sfrRdata;
	logic       storeTimerTick;
	logic       storeDoneClear;
	logic       storeDoneFlag;
	logic       storeBusy;
	logic       fetchBusy;
	int         mismatches;
	int         testsRun;
	int         seed;
	int         i;
	logic [7:0] q;
	logic [7:0] a;
	logic [7:0] d;
	logic [7:0] mem [128];
	logic [7:0] aq [$];

	deac_top #(.STORE_TICKS(STK), .FETCH_CYCLES(FCY)) DUT (
		.mclk(mclk), .reset_n(reset_n), .pointerHighByte(pointerHighByte), .sfrAddr(sfrAddr),
		.sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
		.storeTimerTick(storeTimerTick), .storeDoneClear(storeDoneClear),
		.storeDoneFlag(storeDoneFlag), .storeBusy(storeBusy), .fetchBusy(fetchBusy)
	);

	always #10 mclk = ~mclk;
	// free running store timer, unrelated in phase to mclk
	always #37 storeTimerTick = ~storeTimerTick;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		testsRun++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] sec, input logic [7:0] off, input logic [7:0] dat);
		@(posedge mclk);
		#1;
		pointerHighByte = sec;
		sfrAddr = off;
		sfrWdata = dat;
		sfrWrite = 1'b1;
		@(posedge mclk);
		#1;
		sfrWrite = 1'b0;
	endtask

	task automatic rd(input logic [7:0] sec, input logic [7:0] off, input logic [7:0] exp);
		@(posedge mclk);
		#1;
		pointerHighByte = sec;
		sfrAddr = off;
		sfrRead = 1'b1;
		@(posedge mclk);
		#1;
		sfrRead = 1'b0;
		@(posedge mclk);
		#1;
		chk(sfrRdata, exp, "register read");
	endtask

	task automatic waitIdle();
		int n;
		n = 0;
		while ((storeBusy | fetchBusy) !== 1'b0 && n < 200) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 200) begin
			mismatches++;
			$display("MISMATCH %0t cycle never completed", $time);
		end
	endtask

	task automatic finishTest();
		$display("comparisons %0d mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#200000;
		mismatches++;
		$display("MISMATCH %0t watchdog expired", $time);
		finishTest();
	end

	initial begin
		mclk = 1'b0; reset_n = 1'b0; pointerHighByte = 8'h00; sfrAddr = 8'h00;
		sfrWrite = 1'b0; sfrRead = 1'b0; sfrWdata = 8'h00; storeTimerTick = 1'b0;
		storeDoneClear = 1'b0; mismatches = 0; testsRun = 0; seed = 32'h808535eb;
		repeat (20) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		rd(8'h01, 8'h40, 8'h00);
		rd(8'h00, 8'h2e, 8'h00);
		rd(8'h00, 8'h2f, 8'h00);
		rd(8'h00, 8'h55, 8'h00);
		$display("test reset values done");
		wr(8'h01, 8'h40, 8'h04);
		rd(8'h01, 8'h40, 8'h00);
		chk({7'h00, storeBusy}, 8'h00, "store began without enable");
		wr(8'h01, 8'h40, 8'h01);
		rd(8'h01, 8'h40, 8'h00);
		wr(8'h01, 8'h40, 8'hf0);
		rd(8'h01, 8'h40, 8'h00);
		wr(8'h00, 8'h40, 8'h08);
		rd(8'h01, 8'h40, 8'h00);
		// enable and start in one write: enable not yet set, so no start
		wr(8'h01, 8'h40, 8'h0c);
		rd(8'h01, 8'h40, 8'h08);
		chk({7'h00, storeBusy}, 8'h00, "store began in enabling write");
		wr(8'h01, 8'h40, 8'h00);
		$display("test blocked starts done");
		for (i = 0; i < 6; i++) begin
			a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
			d = 8'($random(seed));
			wr(8'h00, 8'h2e, a);
			wr(8'h00, 8'h2f, d);
			wr(8'h01, 8'h40, 8'h08);
			wr(8'h01, 8'h40, 8'h0c);
			chk({7'h00, storeBusy}, 8'h01, "store did not start");
			waitIdle();
			chk({7'h00, storeDoneFlag}, 8'h01, "done flag not raised");
			rd(8'h01, 8'h40, 8'h08);
			rd(8'h00, 8'h2e, {1'b0, a[6:0]});
			@(posedge mclk);
			#1;
			storeDoneClear = 1'b1;
			@(posedge mclk);
			#1;
			storeDoneClear = 1'b0;
			chk({7'h00, storeDoneFlag}, 8'h00, "done flag not cleared");
			mem[a[6:0]] = d;
			aq.push_back({1'b0, a[6:0]});
		end
		$display("test stores done");
		wr(8'h01, 8'h40, 8'h00);
		foreach (aq[k]) begin
			wr(8'h00, 8'h2e, aq[k]);
			wr(8'h00, 8'h2f, ~mem[aq[k][6:0]]);
			wr(8'h01, 8'h40, 8'h02);
			wr(8'h01, 8'h40, 8'h03);
			chk({7'h00, fetchBusy}, 8'h01, "fetch did not start");
			waitIdle();
			rd(8'h01, 8'h40, 8'h02);
			rd(8'h00, 8'h2f, mem[aq[k][6:0]]);
		end
		$display("test fetches done");
		finishTest();
	end
endmodule
